/* pesc_pkg.sv */
// Package with register map, field positions and reset values of the PHY event status block.
package pesc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] PESC_IDX_CTRL      = 6'h11;
  localparam logic [5:0] PESC_IDX_ISE_ONE   = 6'h12;
  localparam logic [5:0] PESC_IDX_ISE_TWO   = 6'h13;
  localparam logic [5:0] PESC_IDX_FC_COUNT  = 6'h14;
  localparam logic [5:0] PESC_IDX_RE_COUNT  = 6'h15;

  // Bus geometry.
  localparam int         PESC_ADDR_W        = 8;
  localparam int         PESC_DATA_W        = 32;
  localparam logic [1:0] PESC_ALIGN_OK      = 2'h0;

  // Second status and enable register: status in the upper byte, enables in the lower.
  localparam int         PESC_TWO_STAT_LSB  = 8;
  localparam int         PESC_TWO_EN_LSB    = 0;
  localparam int         PESC_EV_EEE        = 7;
  localparam int         PESC_EV_AN_ERR     = 6;
  localparam int         PESC_EV_PAGE       = 5;
  localparam int         PESC_EV_FIFO       = 4;
  localparam int         PESC_EV_XOVER      = 3;
  localparam int         PESC_EV_SLEEP      = 2;
  localparam int         PESC_EV_POL_WOL    = 1;
  localparam int         PESC_EV_JABBER     = 0;

  // First status and enable register: only the two counter half-full positions live here.
  localparam int         PESC_ONE_FC_STAT   = 9;
  localparam int         PESC_ONE_RE_STAT   = 8;
  localparam int         PESC_ONE_FC_EN     = 1;
  localparam int         PESC_ONE_RE_EN     = 0;

  // Control register fields.
  localparam int         PESC_CTRL_LOOP     = 0;
  localparam int         PESC_CTRL_GIE      = 1;

  // Counter limits.
  localparam logic [7:0]  PESC_FC_MAX       = 8'hff;
  localparam logic [7:0]  PESC_FC_HALF      = 8'h7f;
  localparam logic [15:0] PESC_RE_MAX       = 16'hffff;
  localparam logic [15:0] PESC_RE_HALF      = 16'h007f;

  // Reset values.
  localparam logic [7:0]  PESC_RST_BYTE     = 8'h00;
  localparam logic [1:0]  PESC_RST_PAIR     = 2'h0;
  localparam logic [15:0] PESC_RST_WORD     = 16'h0000;
  localparam logic [31:0] PESC_RST_DATA     = 32'h0000_0000;

  typedef struct packed {
    logic [7:0]  two_stat;
    logic [7:0]  two_en;
    logic [1:0]  one_stat;
    logic [1:0]  one_en;
    logic        loop_mode;
    logic        gie;
    logic [7:0]  fc_cnt;
    logic [15:0] re_cnt;
    logic [31:0] rdata;
    logic        slverr;
    logic        irq;
  } pesc_state_s;

endpackage

/* pesc_top.sv */
// PHY second interrupt status/enable register, false carrier and receive error counters.
//
// Function
// - Status bit 15 latches high on an energy-efficient Ethernet error; resets to zero.
// - Status bit 14 latches high on an auto-negotiation error event.
// - Status bit 13 latches high when a negotiation page is received.
// - Status bit 12 latches high on loopback FIFO overflow or underflow.
// - Status bit 11 latches high when crossover status changes.
// - Status bit 10 latches high on a sleep mode event.
// - Status bit 9 latches high on polarity change or wake packet.
// - Status bit 8 latches high when jabber is detected.
// - Read-write enable bits 7..0, reset zero, gate the status eight bits higher.
// - Eight-bit false carrier counter increments once per false carrier event.
// - False carrier counter saturates at its maximum instead of wrapping.
// - False carrier counter passing the half-full threshold raises an event.
// - Reading either counter clears it to zero.
// - Sixteen-bit receive error counter counts invalid symbols while receive data valid.
// - Receive errors are not counted while MII loopback mode is on.
// - Receive error counter saturates at its maximum value.
// - Receive error counter passing 127 (PESC_RE_HALF, not half of its sixteen-bit range) raises an event.
// - Half-full events appear as bits 9 and 8 of the first status register.
// - Event interrupts only reach the output while the global enable is set.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module pesc_top
  import pesc_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [PESC_ADDR_W-1:0] paddr_i,
  input  wire logic [PESC_DATA_W-1:0] pwdata_i,
  input  wire logic [3:0]             pstrb_i,
  output logic                        pready_o,
  output logic      [PESC_DATA_W-1:0] prdata_o,
  output logic                        pslverr_o,
  input  wire logic                   eee_err_i,
  input  wire logic                   an_err_i,
  input  wire logic                   page_rx_i,
  input  wire logic                   fifo_overrun_underrun_i,
  input  wire logic                   xover_chg_i,
  input  wire logic                   sleep_evt_i,
  input  wire logic                   pol_chg_i,
  input  wire logic                   wol_pkt_i,
  input  wire logic                   jabber_i,
  input  wire logic                   false_carrier_i,
  input  wire logic                   rx_dv_i,
  input  wire logic                   rx_invalid_sym_i,
  output logic                        loop_mode_o,
  output logic                        irq_o
);

  // True when the byte address is aligned and names the given register index.
  function automatic logic hit(input logic [PESC_ADDR_W-1:0] addr,
                               input logic [5:0]             idx);
    hit = (addr[1:0] == PESC_ALIGN_OK) && (addr[PESC_ADDR_W-1:2] == idx);
  endfunction

  pesc_state_s q;
  pesc_state_s next_q;

  logic [7:0] two_events;
  logic       setup_rd;
  logic       access_wr;
  logic       fc_inc;
  logic       re_inc;
  logic       fc_half;
  logic       re_half;
  logic       mapped;

  // One event line per status position, the two shared sources merged.
  assign two_events[PESC_EV_EEE]     = eee_err_i;
  assign two_events[PESC_EV_AN_ERR]  = an_err_i;
  assign two_events[PESC_EV_PAGE]    = page_rx_i;
  assign two_events[PESC_EV_FIFO]    = fifo_overrun_underrun_i;
  assign two_events[PESC_EV_XOVER]   = xover_chg_i;
  assign two_events[PESC_EV_SLEEP]   = sleep_evt_i;
  assign two_events[PESC_EV_POL_WOL] = pol_chg_i | wol_pkt_i;
  assign two_events[PESC_EV_JABBER]  = jabber_i;

  // Read side effects happen at the end of the setup cycle, in the same edge that captures
  // the read data, so that an event can never slip in between the sample and the clear.
  assign setup_rd  = psel_i & ~penable_i & ~pwrite_i;
  assign access_wr = psel_i & penable_i & pwrite_i;
  assign mapped    = hit(paddr_i, PESC_IDX_CTRL)     | hit(paddr_i, PESC_IDX_ISE_ONE)  |
                     hit(paddr_i, PESC_IDX_ISE_TWO)  | hit(paddr_i, PESC_IDX_FC_COUNT) |
                     hit(paddr_i, PESC_IDX_RE_COUNT);

  assign fc_inc  = false_carrier_i && (q.fc_cnt != PESC_FC_MAX);
  assign re_inc  = rx_dv_i && rx_invalid_sym_i && !q.loop_mode &&
                   (q.re_cnt != PESC_RE_MAX);
  assign fc_half = fc_inc && (q.fc_cnt == PESC_FC_HALF);
  assign re_half = re_inc && (q.re_cnt == PESC_RE_HALF);

  always_comb begin
    next_q = q;

    // Status read clears first; a new event below then sets again, so set wins.
    if (setup_rd && hit(paddr_i, PESC_IDX_ISE_TWO)) begin
      next_q.two_stat = PESC_RST_BYTE;
    end
    if (setup_rd && hit(paddr_i, PESC_IDX_ISE_ONE)) begin
      next_q.one_stat = PESC_RST_PAIR;
    end
    for (int i = 0; i < 8; i++) begin
      if (two_events[i]) begin
        next_q.two_stat[i] = 1'b1;
      end
    end
    if (fc_half) begin
      next_q.one_stat[PESC_ONE_FC_STAT-PESC_TWO_STAT_LSB] = 1'b1;
    end
    if (re_half) begin
      next_q.one_stat[PESC_ONE_RE_STAT-PESC_TWO_STAT_LSB] = 1'b1;
    end

    // Counters: clear on read, an increment in the same cycle leaves a count of one.
    if (setup_rd && hit(paddr_i, PESC_IDX_FC_COUNT)) begin
      next_q.fc_cnt = PESC_RST_BYTE;
    end
    if (setup_rd && hit(paddr_i, PESC_IDX_RE_COUNT)) begin
      next_q.re_cnt = PESC_RST_WORD;
    end
    if (fc_inc) begin
      next_q.fc_cnt = next_q.fc_cnt + 8'h01;
    end
    if (re_inc) begin
      next_q.re_cnt = next_q.re_cnt + 16'h0001;
    end

    // Writes only reach the enable and control fields; status and counters are read-only.
    if (access_wr && pstrb_i[0]) begin
      if (hit(paddr_i, PESC_IDX_ISE_TWO)) begin
        next_q.two_en = pwdata_i[PESC_TWO_EN_LSB +: 8];
      end
      if (hit(paddr_i, PESC_IDX_ISE_ONE)) begin
        next_q.one_en[0] = pwdata_i[PESC_ONE_RE_EN];
        next_q.one_en[1] = pwdata_i[PESC_ONE_FC_EN];
      end
      if (hit(paddr_i, PESC_IDX_CTRL)) begin
        next_q.loop_mode = pwdata_i[PESC_CTRL_LOOP];
        next_q.gie       = pwdata_i[PESC_CTRL_GIE];
      end
    end

    // Read data and error are captured in the setup cycle and held through the access cycle.
    if (psel_i && !penable_i) begin
      next_q.rdata  = PESC_RST_DATA;
      next_q.slverr = !mapped;
      if (!pwrite_i) begin
        if (hit(paddr_i, PESC_IDX_ISE_TWO)) begin
          next_q.rdata[15:8] = q.two_stat;
          next_q.rdata[7:0]  = q.two_en;
        end
        if (hit(paddr_i, PESC_IDX_ISE_ONE)) begin
          next_q.rdata[PESC_ONE_FC_STAT] = q.one_stat[1];
          next_q.rdata[PESC_ONE_RE_STAT] = q.one_stat[0];
          next_q.rdata[PESC_ONE_FC_EN]   = q.one_en[1];
          next_q.rdata[PESC_ONE_RE_EN]   = q.one_en[0];
        end
        if (hit(paddr_i, PESC_IDX_CTRL)) begin
          next_q.rdata[PESC_CTRL_LOOP] = q.loop_mode;
          next_q.rdata[PESC_CTRL_GIE]  = q.gie;
        end
        if (hit(paddr_i, PESC_IDX_FC_COUNT)) begin
          next_q.rdata[7:0] = q.fc_cnt;
        end
        if (hit(paddr_i, PESC_IDX_RE_COUNT)) begin
          next_q.rdata[15:0] = q.re_cnt;
        end
      end
    end

    // Interrupt output follows the pending and enabled events, gated by the global enable.
    next_q.irq = q.gie && ((|(q.two_stat & q.two_en)) || (|(q.one_stat & q.one_en)));
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q.two_stat  <= PESC_RST_BYTE;
      q.two_en    <= PESC_RST_BYTE;
      q.one_stat  <= PESC_RST_PAIR;
      q.one_en    <= PESC_RST_PAIR;
      q.loop_mode <= 1'b0;
      q.gie       <= 1'b0;
      q.fc_cnt    <= PESC_RST_BYTE;
      q.re_cnt    <= PESC_RST_WORD;
      q.rdata     <= PESC_RST_DATA;
      q.slverr    <= 1'b0;
      q.irq       <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // Zero wait states: every access phase completes at its first edge.
  assign pready_o    = 1'b1;
  assign prdata_o    = q.rdata;
  assign pslverr_o   = q.slverr & psel_i & penable_i;
  assign loop_mode_o = q.loop_mode;
  assign irq_o       = q.irq;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_eee_latch: assert property (eee_err_i |=> q.two_stat[PESC_EV_EEE])
    else $error("eee error did not latch status bit 15");
  a_an_err_latch: assert property (an_err_i |=> q.two_stat[PESC_EV_AN_ERR])
    else $error("negotiation error did not latch status bit 14");
  a_page_latch: assert property (page_rx_i |=> q.two_stat[PESC_EV_PAGE])
    else $error("page received did not latch status bit 13");
  a_fifo_latch: assert property (fifo_overrun_underrun_i |=> q.two_stat[PESC_EV_FIFO])
    else $error("fifo overrun or underrun did not latch status bit 12");
  a_xover_latch: assert property (xover_chg_i |=> q.two_stat[PESC_EV_XOVER])
    else $error("crossover change did not latch status bit 11");
  a_sleep_latch: assert property (sleep_evt_i |=> q.two_stat[PESC_EV_SLEEP])
    else $error("sleep event did not latch status bit 10");
  a_pol_wol_latch: assert property ((pol_chg_i || wol_pkt_i) |=> q.two_stat[PESC_EV_POL_WOL])
    else $error("polarity or wake event did not latch status bit 9");
  a_jabber_latch: assert property (jabber_i |=> q.two_stat[PESC_EV_JABBER])
    else $error("jabber did not latch status bit 8");
  a_status_holds: assert property (
      (q.two_stat != PESC_RST_BYTE) && !(setup_rd && hit(paddr_i, PESC_IDX_ISE_TWO))
      |=> ((q.two_stat & $past(q.two_stat)) == $past(q.two_stat)))
    else $error("latched status bit dropped without a read");
  a_status_rd_clear: assert property (
      setup_rd && hit(paddr_i, PESC_IDX_ISE_TWO) |=> (q.two_stat == $past(two_events)))
    else $error("status read did not clear or lost a same-cycle event");
  a_irq_gate: assert property (!q.gie |=> !irq_o)
    else $error("interrupt raised with global enable clear");
  a_irq_enable: assert property (
      q.gie && ((q.two_stat & q.two_en) != PESC_RST_BYTE) |=> irq_o)
    else $error("enabled pending status did not raise interrupt");
  a_fc_count: assert property (
      false_carrier_i && (q.fc_cnt != PESC_FC_MAX) &&
      !(setup_rd && hit(paddr_i, PESC_IDX_FC_COUNT)) |=> (q.fc_cnt == $past(q.fc_cnt) + 8'h01))
    else $error("false carrier counter did not step by one");
  a_fc_saturate: assert property (
      (q.fc_cnt == PESC_FC_MAX) && !(setup_rd && hit(paddr_i, PESC_IDX_FC_COUNT))
      |=> (q.fc_cnt == PESC_FC_MAX))
    else $error("false carrier counter left its maximum without a read");
  a_fc_half: assert property (
      false_carrier_i && (q.fc_cnt == PESC_FC_HALF) &&
      !(setup_rd && hit(paddr_i, PESC_IDX_ISE_ONE)) |=> q.one_stat[1])
    else $error("false carrier half-full event not reported");
  a_re_half: assert property (
      re_inc && (q.re_cnt == PESC_RE_HALF) &&
      !(setup_rd && hit(paddr_i, PESC_IDX_ISE_ONE)) |=> q.one_stat[0])
    else $error("receive error half-full event not reported");
  a_cnt_rd_clear: assert property (
      setup_rd && hit(paddr_i, PESC_IDX_RE_COUNT) && !re_inc |=> (q.re_cnt == PESC_RST_WORD))
    else $error("receive error counter not cleared by read");
  a_re_loop_hold: assert property (
      q.loop_mode && !(setup_rd && hit(paddr_i, PESC_IDX_RE_COUNT))
      |=> (q.re_cnt == $past(q.re_cnt)))
    else $error("receive error counted during loopback");
  a_re_count: assert property (
      rx_dv_i && rx_invalid_sym_i && !q.loop_mode && (q.re_cnt != PESC_RE_MAX) &&
      !(setup_rd && hit(paddr_i, PESC_IDX_RE_COUNT)) |=> (q.re_cnt == $past(q.re_cnt) + 16'h0001))
    else $error("receive error counter did not step by one");
  a_re_saturate: assert property (
      (q.re_cnt == PESC_RE_MAX) && !(setup_rd && hit(paddr_i, PESC_IDX_RE_COUNT))
      |=> (q.re_cnt == PESC_RE_MAX))
    else $error("receive error counter left its maximum without a read");
  a_fc_reserved: assert property (
      setup_rd && hit(paddr_i, PESC_IDX_FC_COUNT) |=> (prdata_o[31:8] == 24'h00_0000))
    else $error("reserved false carrier bits read nonzero");

  // Register access: writes land at the access edge, read data reflects the setup edge.
  a_two_en_write: assert property (
      access_wr && pstrb_i[0] && hit(paddr_i, PESC_IDX_ISE_TWO)
      |=> (q.two_en == $past(pwdata_i[7:0])))
    else $error("enable byte not written");

  a_two_en_hold: assert property (
      !(access_wr && hit(paddr_i, PESC_IDX_ISE_TWO))
      |=> (q.two_en == $past(q.two_en)))
    else $error("enable byte changed without a write");

  a_two_rdata: assert property (
      setup_rd && hit(paddr_i, PESC_IDX_ISE_TWO)
      |=> (prdata_o[15:0] == {$past(q.two_stat), $past(q.two_en)}))
    else $error("second status read data wrong");

  a_one_rdata: assert property (
      setup_rd && hit(paddr_i, PESC_IDX_ISE_ONE)
      |=> (prdata_o[9:8] == $past(q.one_stat)))
    else $error("half-full status read data wrong");

  a_ctrl_rdata: assert property (
      setup_rd && hit(paddr_i, PESC_IDX_CTRL)
      |=> (prdata_o[1:0] == {$past(q.gie), $past(q.loop_mode)}))
    else $error("control read data wrong");

  a_fc_rdata: assert property (
      setup_rd && hit(paddr_i, PESC_IDX_FC_COUNT)
      |=> (prdata_o[7:0] == $past(q.fc_cnt)))
    else $error("false carrier read data wrong");

  a_re_rdata: assert property (
      setup_rd && hit(paddr_i, PESC_IDX_RE_COUNT)
      |=> (prdata_o[15:0] == $past(q.re_cnt)))
    else $error("receive error read data wrong");

  a_fc_rd_clear: assert property (
      setup_rd && hit(paddr_i, PESC_IDX_FC_COUNT) && !fc_inc
      |=> (q.fc_cnt == PESC_RST_BYTE))
    else $error("false carrier counter not cleared by read");

  a_one_rd_clear: assert property (
      setup_rd && hit(paddr_i, PESC_IDX_ISE_ONE) && !fc_half && !re_half
      |=> (q.one_stat == PESC_RST_PAIR))
    else $error("half-full status not cleared by read");

  a_one_holds: assert property (
      !(setup_rd && hit(paddr_i, PESC_IDX_ISE_ONE))
      |=> ((q.one_stat & $past(q.one_stat)) == $past(q.one_stat)))
    else $error("half-full status dropped without a read");

  a_wr_no_clear: assert property (
      access_wr && hit(paddr_i, PESC_IDX_ISE_TWO)
      |=> ((q.two_stat & $past(q.two_stat)) == $past(q.two_stat)))
    else $error("status write cleared a latched bit");

  a_ctrl_write: assert property (
      access_wr && pstrb_i[0] && hit(paddr_i, PESC_IDX_CTRL)
      |=> (q.loop_mode == $past(pwdata_i[PESC_CTRL_LOOP])) && (q.gie == $past(pwdata_i[PESC_CTRL_GIE])))
    else $error("control bits not written");

  a_re_no_event: assert property (
      !(rx_dv_i && rx_invalid_sym_i) && !(setup_rd && hit(paddr_i, PESC_IDX_RE_COUNT))
      |=> (q.re_cnt == $past(q.re_cnt)))
    else $error("receive error counted without an error");

  a_fc_no_event: assert property (
      !false_carrier_i && !(setup_rd && hit(paddr_i, PESC_IDX_FC_COUNT))
      |=> (q.fc_cnt == $past(q.fc_cnt)))
    else $error("false carrier counted without an event");

  a_fc_half_once: assert property (
      !fc_half && !(setup_rd && hit(paddr_i, PESC_IDX_ISE_ONE))
      |=> (q.one_stat[1] == $past(q.one_stat[1])))
    else $error("false carrier half-full changed without cause");

  a_re_half_once: assert property (
      !re_half && !(setup_rd && hit(paddr_i, PESC_IDX_ISE_ONE))
      |=> (q.one_stat[0] == $past(q.one_stat[0])))
    else $error("receive error half-full changed without cause");

  a_irq_half: assert property (
      q.gie && ((q.one_stat & q.one_en) != PESC_RST_PAIR)
      |=> irq_o)
    else $error("enabled half-full event did not raise interrupt");

  a_status_no_spur: assert property (
      1'b1
      |=> ((q.two_stat & ~$past(q.two_stat) & ~$past(two_events)) == PESC_RST_BYTE))
    else $error("status bit set without an event");

  c_irq_raised: cover property (q.gie ##1 $rose(irq_o));
  c_fc_saturated: cover property (q.fc_cnt == PESC_FC_MAX);
  c_rd_with_event: cover property (setup_rd && hit(paddr_i, PESC_IDX_ISE_TWO) && jabber_i);
  c_re_half_seen: cover property (re_half);
  c_loop_blocked: cover property (q.loop_mode && rx_dv_i && rx_invalid_sym_i);

endmodule

`default_nettype wire

/* pesc_host.sv */
// Management host model that issues register transfers to the event block.
`timescale 1ns/10ps
`default_nettype none

module pesc_host
  import pesc_pkg::*;
(
  input  wire logic                   ref_clk_i,
  output logic                        psel_o,
  output logic                        penable_o,
  output logic                        pwrite_o,
  output logic      [PESC_ADDR_W-1:0] paddr_o,
  output logic      [PESC_DATA_W-1:0] pwdata_o,
  output logic      [3:0]             pstrb_o,
  input  wire logic                   pready_i,
  input  wire logic [PESC_DATA_W-1:0] prdata_i,
  input  wire logic                   pslverr_i
);
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0000_0000;
    pstrb_o   = 4'h0;
  end

  // Only the bench timeout ends a wait for a slave that never answers.
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    rdata = 'x;
    err = 1'bx;
    @(posedge ref_clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= {idx, PESC_ALIGN_OK};
    pwdata_o  <= wdata;
    pstrb_o   <= 4'h1;
    @(posedge ref_clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (pready_i !== 1'b1);
    rdata = prdata_i;
    err = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* pesc_top_bench.sv */
// Self-checking testbench for the PHY event status and counter block.
`timescale 1ns/10ps
`default_nettype none

module pesc_top_bench;
  import pesc_pkg::*;

  logic                   clk;
  logic                   rst;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [PESC_ADDR_W-1:0] paddr;
  logic [PESC_DATA_W-1:0] pwdata;
  logic [3:0]             pstrb;
  logic                   pready;
  logic [PESC_DATA_W-1:0] prdata;
  logic                   pslverr;
  logic [8:0]             ev;
  logic                   fc;
  logic                   rx_dv;
  logic                   rx_bad;
  logic                   loop_mode;
  logic                   irq;
  int                     n_errors;
  int                     num_checks;
  int                     cycles;
  logic [31:0]            d;
  logic                   e;
  logic [15:0]            ev_mask [0:8] = '{16'h0100, 16'h0200, 16'h0200, 16'h0400,
                                            16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h8000};

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ev = 9'h000;
    fc = 1'b0;
    rx_dv = 1'b0;
    rx_bad = 1'b0;
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
  end

  always #5 clk = ~clk;

  pesc_host u_host (.ref_clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .pready_i(pready),
    .prdata_i(prdata), .pslverr_i(pslverr));

  pesc_top u_dut (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .eee_err_i(ev[8]),
    .an_err_i(ev[7]), .page_rx_i(ev[6]), .fifo_overrun_underrun_i(ev[5]),
    .xover_chg_i(ev[4]), .sleep_evt_i(ev[3]), .pol_chg_i(ev[2]), .wol_pkt_i(ev[1]),
    .jabber_i(ev[0]), .false_carrier_i(fc), .rx_dv_i(rx_dv), .rx_invalid_sym_i(rx_bad),
    .loop_mode_o(loop_mode), .irq_o(irq));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input string name);
    u_host.xfer(1'b0, idx, 32'h0000_0000, d, e);
    chk(name, exp, d);
    chk("slave error", 32'h0000_0000, {31'h0, e});
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] data);
    u_host.xfer(1'b1, idx, data, d, e);
    chk("write error", 32'h0000_0000, {31'h0, e});
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask

  // Holding the input high for n edges stands for n back-to-back events.
  task automatic burst(input int sel, input int n);
    @(posedge clk);
    if (sel == 0)
      fc <= 1'b1;
    else
      rx_bad <= 1'b1;
    repeat (n) @(posedge clk);
    fc <= 1'b0;
    rx_bad <= 1'b0;
  endtask

  // The interrupt output trails the pending bit by one registered stage.
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(PESC_IDX_ISE_TWO, 32'h0, "status two reset");
    rd(PESC_IDX_FC_COUNT, 32'h0, "false carrier reset");
    rd(PESC_IDX_RE_COUNT, 32'h0, "receive error reset");
    u_host.xfer(1'b0, 6'h20, 32'h0, d, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      pulse(i);
      rd(PESC_IDX_ISE_TWO, {16'h0, ev_mask[i]}, "event status");
      rd(PESC_IDX_ISE_TWO, 32'h0, "status after read");
    end
    $display("test event status done");
    wr(PESC_IDX_ISE_TWO, 32'h0000_ffff);
    rd(PESC_IDX_ISE_TWO, 32'h0000_00ff, "enable bits");
    wr(PESC_IDX_CTRL, 32'h2);
    pulse(0);
    chk_irq(1'b1);
    rd(PESC_IDX_ISE_TWO, 32'h0000_01ff, "jabber pending");
    chk_irq(1'b0);
    wr(PESC_IDX_CTRL, 32'h0);
    pulse(0);
    chk_irq(1'b0);
    rd(PESC_IDX_ISE_TWO, 32'h0000_01ff, "jabber masked globally");
    wr(PESC_IDX_ISE_TWO, 32'h0);
    wr(PESC_IDX_CTRL, 32'h2);
    pulse(0);
    chk_irq(1'b0);
    rd(PESC_IDX_ISE_TWO, 32'h0000_0100, "jabber not enabled");
    $display("test enables done");
    wr(PESC_IDX_ISE_ONE, 32'h2);
    burst(0, 127);
    rd(PESC_IDX_ISE_ONE, 32'h2, "fc below half");
    burst(0, 1);
    chk_irq(1'b1);
    rd(PESC_IDX_ISE_ONE, 32'h0000_0202, "fc half full");
    rd(PESC_IDX_FC_COUNT, 32'h80, "fc count");
    rd(PESC_IDX_FC_COUNT, 32'h0, "fc cleared");
    burst(0, 300);
    rd(PESC_IDX_FC_COUNT, 32'hff, "fc saturated");
    wr(PESC_IDX_FC_COUNT, 32'h0000_ffff);
    rd(PESC_IDX_FC_COUNT, 32'h0, "fc reserved");
    $display("test false carrier done");
    wr(PESC_IDX_ISE_ONE, 32'h1);
    burst(1, 5);
    rd(PESC_IDX_RE_COUNT, 32'h0, "re without valid");
    rx_dv <= 1'b1;
    wr(PESC_IDX_CTRL, 32'h3);
    #1;
    chk("loop mode", 32'h1, {31'h0, loop_mode});
    burst(1, 5);
    rd(PESC_IDX_RE_COUNT, 32'h0, "re in loopback");
    wr(PESC_IDX_CTRL, 32'h2);
    burst(1, 128);
    chk_irq(1'b1);
    rd(PESC_IDX_ISE_ONE, 32'h0000_0301, "re half full");
    rd(PESC_IDX_RE_COUNT, 32'h80, "re count");
    burst(1, 65540);
    rd(PESC_IDX_RE_COUNT, 32'hffff, "re saturated");
    rd(PESC_IDX_RE_COUNT, 32'h0, "re cleared");
    $display("test receive error done");
    end_of_test();
  end
endmodule

`default_nettype wire
